//--- rtl/spms_pkg.sv
// Purpose: constants and types for the serial master/slave byte port
// Assumes: one 20 MHz clock, plain strobe register port
// Notes: control byte bits 1 and 2 change meaning with the role bit
package spms_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam logic [3:0] ADR_DATA = 4'h0;
   localparam logic [3:0] ADR_CTL = 4'h1;
   localparam logic [3:0] ADR_STS = 4'h2;
   localparam logic [3:0] ADR_MASK = 4'h3;
   localparam int DAT_AVAIL_BIT = 14;
   localparam int DAT_OVR_BIT = 15;
   localparam logic [7:0] CTL_RST = 8'h00;
   localparam logic [7:0] CTL_WMASK = 8'h6f;
   localparam logic [1:0] STS_RST = 2'h0;
   localparam logic [1:0] MASK_RST = 2'h0;
   localparam int IRQ_RX_BIT = 0;
   localparam int IRQ_OVR_BIT = 1;
   // ****************************************
   // Counts
   // ****************************************
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [3:0] LAST_HALF = 4'hf;
   // ****************************************
   // Types
   // ****************************************
   typedef struct packed {
      logic rd;
      logic wr;
      logic [3:0] addr;
      logic [15:0] wdata;
   } spms_req_t;
   typedef struct packed {
      logic rsvd;
      logic clk_src;
      logic ss_pol;
      logic avail;
      logic cpha;
      logic b2;
      logic b1;
      logic master;
   } spms_ctl_t;
   typedef enum logic [0:0] {
      SPMS_IDLE = 1'b0,
      SPMS_XFER = 1'b1
   } spms_st_t;
   // Last count of a half clock period for a divider select
   function automatic logic [2:0] spms_half_last(input logic [1:0] sel);
      logic [3:0] n;
      n = (4'h1 << sel) - 4'h1;
      return n[2:0];
   endfunction
endpackage

//--- rtl/spms_port.sv
// Purpose: byte serial port, master or slave, double buffered receive
// Assumes: pins are outside the clock domain; timer input is on clk
// Notes: master sample sees input two cycles late through the synchroniser
`timescale 1ns/1ns
module spms_port (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Register port
   input wire spms_pkg::spms_req_t bus_req,
   output logic [15:0] rdata,
   // Serial clock pin
   input wire logic sclk_i,
   output logic sclk_o,
   output logic sclk_oe,
   // Select and data pins
   input wire logic ss_i,
   input wire logic sdi_i,
   output logic sdo_o,
   output logic sdo_oe,
   // Timer zero output
   input wire logic timer_zero_output,
   // Interrupt
   output logic irq
);
   import spms_pkg::*;

   // ****************************************
   // Storage
   // ****************************************
   spms_ctl_t ctl_q;
   spms_st_t st_q;
   spms_st_t st_d;
   logic [7:0] tx_q;
   logic [7:0] rx_q;
   logic [7:0] hold_q;
   logic [2:0] bitcnt_q;
   logic [2:0] hcnt_q;
   logic [3:0] hticks_q;
   logic sclk_q;
   logic tmr_q;
   logic avail_q;
   logic ovr_q;
   logic [1:0] sts_q;
   logic [1:0] mask_q;
   logic [15:0] rdata_q;
   logic sclk_s1;
   logic sclk_s2;
   logic sclk_s3;
   logic ss_s1;
   logic ss_s2;
   logic sdi_s1;
   logic sdi_s2;

   // ****************************************
   // Register decode
   // ****************************************
   wire rd_dat = bus_req.rd & (bus_req.addr == ADR_DATA);
   wire wr_dat = bus_req.wr & (bus_req.addr == ADR_DATA);
   wire wr_ctl = bus_req.wr & (bus_req.addr == ADR_CTL);
   wire wr_sts = bus_req.wr & (bus_req.addr == ADR_STS);
   wire wr_mask = bus_req.wr & (bus_req.addr == ADR_MASK);
   wire master = ctl_q.master;

   // ****************************************
   // Master clock generation
   // ****************************************
   // Half period length, or any change of the timer output
   wire [2:0] half_last = spms_half_last({ctl_q.b2, ctl_q.b1});
   wire tmr_edge = timer_zero_output ^ tmr_q;
   wire busy = (st_q == SPMS_XFER);
   wire div_tick = (hcnt_q == half_last);
   wire mtick = busy & (ctl_q.clk_src ? tmr_edge : div_tick);
   wire start = wr_dat & master & ~busy;
   wire m_lead = mtick & ~sclk_q;
   wire m_trail = mtick & sclk_q;
   wire m_end = mtick & (hticks_q == LAST_HALF);

   // Next state of the master sequencer
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         SPMS_IDLE: begin
            if (start) begin
               st_d = SPMS_XFER;
            end
         end
         SPMS_XFER: begin
            if (m_end | ~master) begin
               st_d = SPMS_IDLE;
            end
         end
      endcase
   end

   // ****************************************
   // Slave edge detection
   // ****************************************
   wire ss_act = (ss_s2 == ctl_q.ss_pol);
   wire s_act = ~master & ss_act;
   wire s_lead = s_act & sclk_s2 & ~sclk_s3;
   wire s_trail = s_act & ~sclk_s2 & sclk_s3;

   // ****************************************
   // Shared shift events
   // ****************************************
   // Sample on one edge, launch on the other
   wire lead = m_lead | s_lead;
   wire trail = m_trail | s_trail;
   wire sample = ctl_q.cpha ? trail : lead;
   wire launch = ctl_q.cpha ? lead : trail;
   wire [7:0] rx_next = {rx_q[6:0], sdi_s2};
   wire done = sample & (bitcnt_q == LAST_BIT);
   wire bit_clr = start | (~master & ~ss_act);
   wire tx_load = wr_dat & (~master | start);
   wire tx_shift = launch & (bitcnt_q != 3'h0);

   // ****************************************
   // Flags
   // ****************************************
   // Set by a finished byte, cleared by a buffer read; set wins
   wire avail_d = done | (avail_q & ~rd_dat);
   wire ovr_set = done & avail_q & ~rd_dat;
   wire ovr_clr = wr_ctl & ~master & ~bus_req.wdata[1];
   wire ovr_d = ovr_set | (ovr_q & ~ovr_clr);
   wire [1:0] sts_set = {ovr_set, done};
   wire [1:0] sts_clr = wr_sts ? bus_req.wdata[1:0] : 2'h0;
   wire [1:0] sts_d = sts_set | (sts_q & ~sts_clr);
   wire [7:0] ctl_wval = bus_req.wdata[7:0] & CTL_WMASK;

   // ****************************************
   // Read data
   // ****************************************
   wire [15:0] dat_word = {ovr_q, avail_q, 6'h00, hold_q};
   wire ctl_b1 = master ? ctl_q.b1 : ovr_q;
   wire [7:0] ctl_byte = {1'b0, ctl_q.clk_src, ctl_q.ss_pol, avail_q,
                          ctl_q.cpha, ctl_q.b2, ctl_b1, ctl_q.master};
   wire [15:0] rd_mux =
      (bus_req.addr == ADR_DATA) ? dat_word :
      (bus_req.addr == ADR_CTL) ? {8'h00, ctl_byte} :
      (bus_req.addr == ADR_STS) ? {14'h0000, sts_q} :
      (bus_req.addr == ADR_MASK) ? {14'h0000, mask_q} : 16'h0000;

   // ****************************************
   // Synchronisers
   // ****************************************
   // Two stages per pin; third clock stage only for edge finding
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sclk_s1 <= 1'b0;
         sclk_s2 <= 1'b0;
         sclk_s3 <= 1'b0;
         ss_s1 <= 1'b1; // Idle high so the default low select reads inactive
         ss_s2 <= 1'b1;
         sdi_s1 <= 1'b0;
         sdi_s2 <= 1'b0;
      end else begin
         sclk_s1 <= sclk_i;
         sclk_s2 <= sclk_s1;
         sclk_s3 <= sclk_s2;
         ss_s1 <= ss_i;
         ss_s2 <= ss_s1;
         sdi_s1 <= sdi_i;
         sdi_s2 <= sdi_s1;
      end
   end

   // ****************************************
   // Registers written by software
   // ****************************************
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctl_q <= spms_ctl_t'(CTL_RST);
         mask_q <= MASK_RST;
      end else begin
         if (wr_ctl) begin
            ctl_q <= spms_ctl_t'(ctl_wval);
         end
         if (wr_mask) begin
            mask_q <= bus_req.wdata[1:0];
         end
      end
   end

   // ****************************************
   // Master sequencer and clock
   // ****************************************
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_q <= SPMS_IDLE;
         hcnt_q <= 3'h0;
         hticks_q <= 4'h0;
         sclk_q <= 1'b0;
         tmr_q <= 1'b0;
      end else begin
         st_q <= st_d;
         tmr_q <= timer_zero_output;
         if (start | div_tick | ~busy) begin
            hcnt_q <= 3'h0;
         end else begin
            hcnt_q <= hcnt_q + 3'h1;
         end
         if (start) begin
            hticks_q <= 4'h0;
         end else if (mtick) begin
            hticks_q <= hticks_q + 4'h1;
         end
         if (~master | start) begin
            sclk_q <= 1'b0;
         end else if (mtick) begin
            sclk_q <= ~sclk_q;
         end
      end
   end

   // ****************************************
   // Shift path
   // ****************************************
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tx_q <= 8'h00;
         rx_q <= 8'h00;
         bitcnt_q <= 3'h0;
      end else begin
         if (tx_load) begin
            tx_q <= bus_req.wdata[7:0];
         end else if (tx_shift) begin
            tx_q <= {tx_q[6:0], 1'b0};
         end
         if (sample) begin
            rx_q <= rx_next;
         end
         if (bit_clr) begin
            bitcnt_q <= 3'h0;
         end else if (sample) begin
            bitcnt_q <= bitcnt_q + 3'h1;
         end
      end
   end

   // ****************************************
   // Holding buffer and flags
   // ****************************************
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hold_q <= 8'h00;
         avail_q <= 1'b0;
         ovr_q <= 1'b0;
         sts_q <= STS_RST;
      end else begin
         if (done) begin
            hold_q <= rx_next;
         end
         avail_q <= avail_d;
         ovr_q <= ovr_d;
         sts_q <= sts_d;
      end
   end

   // ****************************************
   // Read data register
   // ****************************************
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= 16'h0000;
      end else begin
         rdata_q <= bus_req.rd ? rd_mux : 16'h0000;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign rdata = rdata_q;
   assign sclk_o = sclk_q & master; // No stale high for the cycle after an abort
   assign sclk_oe = master;
   assign sdo_o = tx_q[7];
   assign sdo_oe = master | (ss_act & ctl_q.b2);
   assign irq = |(sts_q & mask_q);

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   AST_RD_DATA: assert property (
      rd_dat |=> rdata == $past(dat_word))
      else $error("data read returned wrong word");

   AST_AVAIL_CLR: assert property (
      rd_dat && !done
      |=> !avail_q && rdata[DAT_AVAIL_BIT] == $past(avail_q))
      else $error("buffer read did not clear available");

   AST_DONE_HOLD: assert property (
      done |=> avail_q && hold_q == $past(rx_next))
      else $error("finished byte not in holding buffer");

   AST_OVERRUN: assert property (
      done && avail_q && !rd_dat |=> ovr_q)
      else $error("overrun flag not set");

   AST_OVR_CLEAR: assert property (
      ovr_clr && !ovr_set |=> !ovr_q)
      else $error("overrun flag not cleared");

   AST_SDO_FLOAT: assert property (
      !master && !ctl_q.b2 |-> !sdo_oe)
      else $error("data output driven while disabled");

   AST_CLK_DRIVE: assert property (
      sclk_oe == master && (master || !sclk_o))
      else $error("serial clock drive wrong for role");

   AST_IRQ_RX: assert property (
      done && mask_q[IRQ_RX_BIT] && !wr_mask |=> irq)
      else $error("interrupt missing after byte");

   AST_MSB_FIRST: assert property (
      start |=> sdo_o == $past(bus_req.wdata[7]) && busy)
      else $error("first bit out is not the MSB");

   AST_MASTER_LEN: assert property (
      start && !ctl_q.clk_src && half_last == 3'h0 && !wr_ctl
      |=> busy [*8] ##1 busy [*8] ##1 !busy)
      else $error("divide by two transfer length wrong");

   AST_SS_GATE: assert property (
      !master && !ss_act |=> bitcnt_q == 3'h0)
      else $error("slave shifted without select");

   AST_OVR_IRQ: assert property (
      ovr_set |=> sts_q[IRQ_OVR_BIT])
      else $error("overrun status not set");

   // Register port, shift path and timer clock
   AST_RDATA_IDLE: assert property (
      !bus_req.rd |=> rdata == 16'h0000)
      else $error("read data present without a read");

   AST_CTL_READ: assert property (
      bus_req.rd && bus_req.addr == ADR_CTL |=> rdata[15:7] == 9'h000 &&
      rdata[4] == $past(avail_q) && rdata[0] == $past(ctl_q.master))
      else $error("control byte read wrong");

   AST_SLAVE_LOAD: assert property (
      wr_dat && !master |=> tx_q == $past(bus_req.wdata[7:0]))
      else $error("slave data write did not load the shift register");

   AST_START_LOAD: assert property (
      start |=> tx_q == $past(bus_req.wdata[7:0]))
      else $error("transfer start did not load the shift register");

   AST_TIMER_HOLD: assert property (
      busy && master && ctl_q.clk_src && !tmr_edge && !wr_ctl
      |=> sclk_o == $past(sclk_o))
      else $error("serial clock moved without a timer change");

   AST_STS_SET: assert property (
      done |=> sts_q[IRQ_RX_BIT])
      else $error("byte status not set");

   AST_SDO_SHIFT: assert property (
      tx_shift && !tx_load |=> sdo_o == $past(tx_q[6]))
      else $error("data output did not advance one bit");

   AST_RX_LAST: assert property (
      done |=> hold_q[0] == $past(sdi_s2))
      else $error("last received bit not at the bottom of the buffer");

   CV_MASTER_DONE: cover property (busy && done);
   CV_SLAVE_DONE: cover property (!master && done);
   CV_OVERRUN: cover property (ovr_set);
   CV_IRQ: cover property (irq && mask_q[IRQ_OVR_BIT]);
   CV_LATE_PHASE: cover property (busy && ctl_q.cpha && done);
endmodule

//--- testbench/spms_partner.sv
// Purpose: behavioural bus master that faces the port in slave role
// Assumes: select active low, clock idle low, sample on rising edge
// Notes: clock stands still between frames; data line inverts when released
`timescale 1ns/1ns
module spms_partner (
   // Clock and start
   input wire logic clk,
   input wire logic go,
   input wire logic [7:0] tx,
   // Pins
   input wire logic sdo,
   output logic sclk,
   output logic ss_n,
   output logic sdi,
   // Result
   output logic busy,
   output logic [7:0] rx
);
   localparam int HALF = 6;
   // One frame of eight bits per start request
   initial begin
      sclk = 1'b0;
      ss_n = 1'b1;
      sdi = 1'b0;
      busy = 1'b0;
      rx = 8'h00;
      forever begin
         @(posedge clk);
         if (go) begin
            busy <= 1'b1;
            ss_n <= 1'b0;
            for (int i = 7; i >= 0; i--) begin
               sdi <= tx[i]; // Top bit first
               repeat (HALF) @(posedge clk);
               sclk <= 1'b1;
               rx <= {rx[6:0], sdo};
               repeat (HALF) @(posedge clk);
               sclk <= 1'b0;
            end
            repeat (HALF) @(posedge clk);
            ss_n <= 1'b1;
            sdi <= ~sdi; // Released line shows no stale value
            busy <= 1'b0;
         end
      end
   end
endmodule

//--- testbench/spms_port_tb.sv
// Purpose: self-checking bench for the serial byte port
// Assumes: pull-up on the data out pin, partner master in slave tests
// Notes: master receive is checked by loopback; fast dividers see the old bit first
`timescale 1ns/1ns
module spms_port_tb;
   import spms_pkg::*;
   logic clk, nrst, tz, go, lb_ss_n, lb, irq;
   logic sclk_o, sclk_oe, sdo_o, sdo_oe, p_sclk, p_ss_n, p_sdi, p_busy;
   logic [7:0] p_tx, p_rx, ta;
   logic [15:0] rdata, v;
   logic [3:0] a;
   logic [31:0] seed;
   spms_req_t req;
   int n_errors, checked;
   wire sdo_pin = sdo_oe ? sdo_o : 1'b1; // Pulled up when floating
   wire sdi_pin = lb_ss_n ? p_sdi : sdo_pin; // Loopback slave answers while selected
   spms_port spms_port_inst (.clk(clk), .nrst(nrst), .bus_req(req), .rdata(rdata),
      .sclk_i(p_sclk), .sclk_o(sclk_o), .sclk_oe(sclk_oe), .ss_i(p_ss_n),
      .sdi_i(sdi_pin), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .timer_zero_output(tz),
      .irq(irq));
   spms_partner spms_partner_inst (.clk(clk), .go(go), .tx(p_tx), .sdo(sdo_pin),
      .sclk(p_sclk), .ss_n(p_ss_n), .sdi(p_sdi), .busy(p_busy), .rx(p_rx));
   // ****************************************
   // Clocks, timer and watchdog
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      tz = 1'b0;
      forever begin
         repeat (3) @(posedge clk);
         tz <= ~tz;
      end
   end
   initial begin
      #1000000;
      n_errors++;
      results;
   end
   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic [15:0] dword(input logic o, input logic f, input logic [7:0] b);
      return {o, f, 6'h00, b};
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   task automatic results;
      if (n_errors == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic wr(input logic [3:0] ad, input logic [15:0] d);
      req <= '{rd: 1'b0, wr: 1'b1, addr: ad, wdata: d};
      @(posedge clk);
      req <= '0;
      @(posedge clk);
   endtask
   task automatic rchk(input logic [3:0] ad, input logic [15:0] e);
      req <= '{rd: 1'b1, wr: 1'b0, addr: ad, wdata: 16'h0000};
      @(posedge clk);
      req <= '0;
      @(negedge clk);
      v = rdata;
      chk(v, e);
      @(posedge clk);
   endtask
   task automatic chk_irq(input logic e);
      @(negedge clk);
      chk({15'h0000, irq}, {15'h0000, e});
      @(posedge clk);
   endtask
   // Master transfer at divider select m, or timer clock for m of 4, phase ph
   task automatic mx(input int m, input logic ph);
      logic [7:0] c, b, e;
      int last, rises, t;
      logic prev;
      c = ((m == 4) ? 8'h41 : {5'h00, m[1:0], 1'b1}) | {4'h0, ph, 3'h0};
      seed = xs(seed);
      b = seed[7:0];
      // Fast dividers sample the first bit before the new MSB is through the sync
      e = (m >= 2) ? b : {lb, b[7:1]};
      wr(ADR_CTL, {8'h00, c | 8'h90});
      rchk(ADR_CTL, {8'h00, c});
      // Start just after a timer change so the first half period is whole
      if (m == 4) @(tz);
      wr(ADR_DATA, {8'h00, b});
      last = 0;
      rises = 0;
      prev = 1'b0;
      for (t = 1; t < 400; t++) begin
         @(negedge clk);
         if (sclk_o !== prev) begin
            if (last > 0) chk(16'(t - last), (m == 4) ? 16'd3 : 16'(1 << m));
            last = t;
            if (sclk_o === 1'b1 && rises < 8) chk({15'h0, sdo_o}, {15'h0, b[7 - rises]});
            if (sclk_o === 1'b1) rises++;
         end
         prev = sclk_o;
      end
      chk(16'(rises), 16'd8);
      chk({15'h0000, sclk_oe}, 16'h0001);
      @(posedge clk);
      chk_irq(1'b1);
      rchk(ADR_DATA, dword(1'b0, 1'b1, e));
      rchk(ADR_DATA, dword(1'b0, 1'b0, e));
      lb = b[0];
      wr(ADR_STS, 16'h0003);
   endtask
   task automatic frame(input logic [7:0] b, input logic oe);
      p_tx <= b;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      for (int k = 0; k < 300; k++) begin
         @(negedge clk);
         if (k == 40) chk({15'h0000, sdo_oe}, {15'h0000, oe});
         if (k > 2 && p_busy === 1'b0) break;
      end
      repeat (6) @(posedge clk);
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      nrst = 1'b0;
      req = '0;
      go = 1'b0;
      p_tx = 8'h00;
      lb_ss_n = 1'b1;
      lb = 1'b0;
      seed = 32'h48b9;
      n_errors = 0;
      checked = 0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      @(negedge clk);
      chk({13'h0000, irq, sclk_oe, sdo_oe}, 16'h0000);
      @(posedge clk);
      rchk(ADR_CTL, {8'h00, CTL_RST});
      rchk(ADR_STS, {14'h0000, STS_RST});
      rchk(ADR_MASK, {14'h0000, MASK_RST});
      rchk(ADR_DATA, 16'h0000);
      // Unmapped places read zero and keep nothing
      for (int i = 0; i < 4; i++) begin
         seed = xs(seed);
         a = 4'h4 + 4'(seed[3:0] % 12);
         wr(a, seed[15:0]);
         rchk(a, 16'h0000);
      end
      wr(ADR_MASK, 16'h0001);
      lb_ss_n <= 1'b0;
      for (int m = 0; m < 5; m++) mx(m, 1'b0);
      mx(3, 1'b1); // Late sampling phase
      lb_ss_n <= 1'b1;
      // Slave role, output enabled, select active low
      wr(ADR_CTL, 16'h0004);
      wr(ADR_MASK, 16'h0003);
      seed = xs(seed);
      ta = seed[7:0];
      wr(ADR_DATA, {8'h00, ta});
      frame(seed[15:8], 1'b1);
      chk({8'h00, p_rx}, {8'h00, ta});
      chk_irq(1'b1);
      rchk(ADR_CTL, 16'h0014);
      rchk(ADR_STS, 16'h0001);
      rchk(ADR_DATA, dword(1'b0, 1'b1, seed[15:8]));
      rchk(ADR_DATA, dword(1'b0, 1'b0, seed[15:8]));
      wr(ADR_STS, 16'h0001);
      // Output floated, two bytes with no read between
      wr(ADR_CTL, 16'h0000);
      frame(seed[23:16], 1'b0);
      chk({8'h00, p_rx}, 16'h00ff);
      frame(seed[31:24], 1'b0);
      rchk(ADR_CTL, 16'h0012);
      rchk(ADR_STS, 16'h0003);
      wr(ADR_MASK, 16'h0000);
      chk_irq(1'b0);
      wr(ADR_MASK, 16'h0003);
      rchk(ADR_DATA, dword(1'b1, 1'b1, seed[31:24]));
      wr(ADR_CTL, 16'h0000);
      rchk(ADR_CTL, 16'h0000);
      rchk(ADR_DATA, dword(1'b0, 1'b0, seed[31:24]));
      wr(ADR_STS, 16'h0003);
      chk_irq(1'b0);
      results;
   end
endmodule
